// ===== core/core_map.svh
`ifndef CORE_MAP_SVH
`define CORE_MAP_SVH

// system clocks per instruction cycle and the last phase index
`define CLKS_PER_ICYCLE 4
`define PHASE_LAST 2'h3
// special data memory locations
`define PC_LOW_ADDR 8'h06
`define TBL_PTR_ADDR 8'h07
`define PORT_ADDR 8'h08
// reset values
`define PC_RST 11'h000
`define ACCUM_RST 8'h00
`define TBL_PTR_RST 8'h00
`define PORT_RST 8'h00

`endif

// ===== core/instr_pkg.sv
package instr_pkg;

	// instruction kinds
	typedef enum logic [3:0] {
		K_NOP = 4'b0000,
		K_ALU_MEM = 4'b0001,
		K_ALU_IMM = 4'b0010,
		K_MOVE_TO_MEM = 4'b0011,
		K_BIT_SET = 4'b0100,
		K_BIT_CLEAR = 4'b0101,
		K_JUMP = 4'b0110,
		K_CALL = 4'b0111,
		K_RETURN = 4'b1000,
		K_RETURN_IMM = 4'b1001,
		K_INT_RETURN = 4'b1010,
		K_SKIP_ZERO = 4'b1011,
		K_SKIP_BIT_ZERO = 4'b1100,
		K_SKIP_BIT_SET = 4'b1101,
		K_TABLE_READ = 4'b1110,
		K_POWER_DOWN = 4'b1111
	} kind_t;

	// alu functions
	typedef enum logic [3:0] {
		FN_PASS = 4'b0000,
		FN_ADD = 4'b0001,
		FN_ADD_CARRY = 4'b0010,
		FN_SUB = 4'b0011,
		FN_SUB_CARRY = 4'b0100,
		FN_AND = 4'b0101,
		FN_OR = 4'b0110,
		FN_XOR = 4'b0111,
		FN_COMPLEMENT = 4'b1000,
		FN_INC = 4'b1001,
		FN_DEC = 4'b1010,
		FN_ROT_RIGHT = 4'b1011,
		FN_ROT_LEFT = 4'b1100,
		FN_ROT_RIGHT_CARRY = 4'b1101,
		FN_ROT_LEFT_CARRY = 4'b1110
	} alu_fn_t;

	// program memory word
	typedef struct packed {
		kind_t kind;
		alu_fn_t fn;
		logic to_mem;
		logic [2:0] bit_idx;
		logic [10:0] operand;
	} instr_t;

	// alu answer
	typedef struct packed {
		logic [7:0] res;
		logic carry;
		logic carry_we;
		logic zero_we;
	} alu_res_t;

endpackage

// ===== core/alu8.sv
`timescale 1ns/10ps
module alu8 (
	input wire logic [7:0] a_in, // accumulator operand
	input wire logic [7:0] b_in, // memory or immediate operand
	input wire logic c_in, // carry flag
	input wire instr_pkg::alu_fn_t fn_in, // function
	output instr_pkg::alu_res_t res_out // result and flag updates
);
	// shared adder; subtract adds the inverse, carry high means no borrow
	wire is_sub = fn_in == instr_pkg::FN_SUB || fn_in == instr_pkg::FN_SUB_CARRY;
	wire use_c = fn_in == instr_pkg::FN_ADD_CARRY ||
		fn_in == instr_pkg::FN_SUB_CARRY;
	wire add_cin = use_c ? c_in : is_sub;
	wire [7:0] b_add = is_sub ? ~b_in : b_in;
	wire [8:0] sum = {1'b0, a_in} + {1'b0, b_add} + {8'h00, add_cin};

	// function select
	always_comb begin
		res_out = '{res: b_in, carry: c_in, carry_we: 1'b0, zero_we: 1'b0};
		case (fn_in)
			instr_pkg::FN_ADD, instr_pkg::FN_ADD_CARRY,
			instr_pkg::FN_SUB, instr_pkg::FN_SUB_CARRY: begin
				res_out = '{res: sum[7:0], carry: sum[8], carry_we: 1'b1,
					zero_we: 1'b1};
			end
			instr_pkg::FN_AND: res_out = '{a_in & b_in, c_in, 1'b0, 1'b1};
			instr_pkg::FN_OR: res_out = '{a_in | b_in, c_in, 1'b0, 1'b1};
			instr_pkg::FN_XOR: res_out = '{a_in ^ b_in, c_in, 1'b0, 1'b1};
			instr_pkg::FN_COMPLEMENT: res_out = '{~b_in, c_in, 1'b0, 1'b1};
			instr_pkg::FN_INC: res_out = '{b_in + 8'h01, c_in, 1'b0, 1'b1};
			instr_pkg::FN_DEC: res_out = '{b_in - 8'h01, c_in, 1'b0, 1'b1};
			instr_pkg::FN_ROT_RIGHT: begin
				res_out.res = {b_in[0], b_in[7:1]};
			end
			instr_pkg::FN_ROT_LEFT: begin
				res_out.res = {b_in[6:0], b_in[7]};
			end
			instr_pkg::FN_ROT_RIGHT_CARRY: begin
				res_out = '{{c_in, b_in[7:1]}, b_in[0], 1'b1, 1'b0};
			end
			instr_pkg::FN_ROT_LEFT_CARRY: begin
				res_out = '{{b_in[6:0], c_in}, b_in[7], 1'b1, 1'b0};
			end
			default: res_out.res = b_in;
		endcase
	end
endmodule

// ===== core/instruction_cycle_timing.sv
`timescale 1ns/10ps
`include "core_map.svh"
// Function
// - most instructions one cycle; jump, call, returns, table read take two
// - one instruction cycle is four system clocks
// - writing the program counter low byte costs one extra cycle
// - skip costs one cycle, plus one extra when the skip is taken
// - skip either runs the next instruction or resumes after it
// - moves are memory to accumulator, accumulator to memory, immediate
// - add reports carry above 255, subtract reports borrow below 0
// - increment and decrement change the value by exactly one
// - logical operations set zero flag exactly when result is zero
// - data operations take one operand through the accumulator
// - rotates shift the operand one bit left or right
// - carry rotates swap the outgoing bit and the old carry
// - call saves the return address, return resumes after it
// - bit set and clear change only the addressed bit
// - table read fetches fixed data from program memory
// - a dedicated instruction enters power-down
module instruction_cycle_timing #(
	parameter int PC_W = 11, // program address width
	parameter int DM_DEPTH = 64, // data memory bytes, power of two
	parameter int STACK_DEPTH = 8 // return address entries
) (
	input wire logic mclk_in, // system clock
	input wire logic rst_n_in, // async reset, active low
	input wire instr_pkg::instr_t prog_data_in, // program memory word
	input wire logic wake_in, // wake-up pin, asynchronous
	output logic [PC_W-1:0] prog_addr_out, // program memory address
	output logic [7:0] accum_out, // accumulator
	output logic zero_out, // zero flag
	output logic carry_out, // carry flag
	output logic [7:0] port_out, // output port latch
	output logic power_down_out, // core halted
	output logic icycle_last_out // high in last clock of each cycle
);
	localparam int DM_AW = $clog2(DM_DEPTH);
	localparam int SP_W = $clog2(STACK_DEPTH);

	logic [1:0] phase_r;
	logic flush_r;
	logic pd_r;
	logic wake_m_r;
	logic wake_s_r;
	logic icyc_r;
	instr_pkg::instr_t ir_r;
	logic [PC_W-1:0] pc_r;
	logic [PC_W-1:0] pc_nxt;
	logic [PC_W-1:0] prog_addr_r;
	logic [7:0] accum_r;
	logic [7:0] tblp_r;
	logic [7:0] port_r;
	logic zero_r;
	logic carry_r;
	logic [SP_W-1:0] sp_r;
	logic [PC_W-1:0] stack_r [STACK_DEPTH];
	logic [7:0] dm_r [DM_DEPTH];
	instr_pkg::alu_res_t alu_res;

	// phase and execute qualifiers
	wire cyc_end = phase_r == `PHASE_LAST;
	wire step = cyc_end && !flush_r && !pd_r;
	instr_pkg::kind_t k;
	assign k = ir_r.kind;
	wire k_alu = k == instr_pkg::K_ALU_MEM || k == instr_pkg::K_ALU_IMM;
	wire k_imm = k == instr_pkg::K_ALU_IMM || k == instr_pkg::K_RETURN_IMM;
	wire k_ret = k == instr_pkg::K_RETURN || k == instr_pkg::K_RETURN_IMM ||
		k == instr_pkg::K_INT_RETURN;
	wire k_goto = k == instr_pkg::K_JUMP || k == instr_pkg::K_CALL;
	wire k_skip = k == instr_pkg::K_SKIP_ZERO ||
		k == instr_pkg::K_SKIP_BIT_ZERO || k == instr_pkg::K_SKIP_BIT_SET;
	wire k_tab = k == instr_pkg::K_TABLE_READ;

	// data memory read with special locations in front
	wire [7:0] m_addr = ir_r.operand[7:0];
	wire is_pcl = m_addr == `PC_LOW_ADDR;
	wire is_tblp = m_addr == `TBL_PTR_ADDR;
	wire is_port = m_addr == `PORT_ADDR;
	wire in_dm = {24'h00_0000, m_addr} < DM_DEPTH;
	wire [7:0] dm_rd = dm_r[m_addr[DM_AW-1:0]];
	wire [7:0] m_rd = is_pcl ? pc_r[7:0] : is_tblp ? tblp_r :
		is_port ? port_r : in_dm ? dm_rd : 8'h00;

	// second operand: memory or immediate, the first is always the accumulator
	wire [7:0] b_op = k_imm ? ir_r.operand[7:0] : m_rd;

	alu8 u_alu (
		.a_in(accum_r),
		.b_in(b_op),
		.c_in(carry_r),
		.fn_in(ir_r.fn),
		.res_out(alu_res)
	);

	// bit operations and skip tests
	wire [7:0] bmask = 8'h01 << ir_r.bit_idx;
	wire bit_hi = |(m_rd & bmask);
	wire skip_hit = (k == instr_pkg::K_SKIP_ZERO && alu_res.res == 8'h00) ||
		(k == instr_pkg::K_SKIP_BIT_ZERO && !bit_hi) ||
		(k == instr_pkg::K_SKIP_BIT_SET && bit_hi);

	// memory write; a plain zero test writes nothing back
	wire skip_wr = k == instr_pkg::K_SKIP_ZERO &&
		ir_r.fn != instr_pkg::FN_PASS;
	wire m_we = step && (k == instr_pkg::K_MOVE_TO_MEM ||
		k == instr_pkg::K_BIT_SET || k == instr_pkg::K_BIT_CLEAR ||
		((k == instr_pkg::K_ALU_MEM || skip_wr) && ir_r.to_mem));
	wire [7:0] m_wd = k == instr_pkg::K_MOVE_TO_MEM ? accum_r :
		k == instr_pkg::K_BIT_SET ? (m_rd | bmask) :
		k == instr_pkg::K_BIT_CLEAR ? (m_rd & ~bmask) : alu_res.res;
	wire pcl_wr = m_we && is_pcl;

	// accumulator write
	wire a_we = step && (k == instr_pkg::K_ALU_IMM || k_tab ||
		k == instr_pkg::K_RETURN_IMM ||
		((k == instr_pkg::K_ALU_MEM || k == instr_pkg::K_SKIP_ZERO) &&
		!ir_r.to_mem));
	wire [7:0] a_wd = k_tab ? prog_data_in.operand[7:0] : alu_res.res;
	wire flag_upd = step && k_alu;

	// flow redirection drops the prefetched word
	wire redirect = k_goto || k_ret || k_tab || (k_skip && skip_hit) ||
		pcl_wr;
	wire [PC_W-1:0] stack_top = stack_r[sp_r - 1'b1];

	// next program counter
	always_comb begin
		pc_nxt = pc_r + 1'b1;
		if (pd_r) begin
			pc_nxt = pc_r;
		end else if (step && k_goto) begin
			pc_nxt = ir_r.operand[PC_W-1:0];
		end else if (step && k_ret) begin
			pc_nxt = stack_top;
		end else if (step && k_tab) begin
			pc_nxt = pc_r;
		end else if (pcl_wr) begin
			pc_nxt = {pc_r[PC_W-1:8], m_wd};
		end
	end

	// four-clock phase counter
	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			phase_r <= 2'h0;
			icyc_r <= 1'b0;
		end else begin
			phase_r <= phase_r + 2'h1;
			icyc_r <= phase_r == 2'h2;
		end
	end

	// fetch, flush and program counter
	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			pc_r <= `PC_RST;
			ir_r <= '0;
			flush_r <= 1'b1;
			prog_addr_r <= `PC_RST;
		end else begin
			if (phase_r == 2'h0) begin
				prog_addr_r <= (k_tab && !flush_r && !pd_r) ?
					{pc_r[PC_W-1:8], tblp_r} : pc_r;
			end
			if (cyc_end && !pd_r) begin
				pc_r <= pc_nxt;
				ir_r <= prog_data_in;
				flush_r <= step && redirect;
			end
		end
	end

	// accumulator, flags and special registers
	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			accum_r <= `ACCUM_RST;
			zero_r <= 1'b0;
			carry_r <= 1'b0;
			tblp_r <= `TBL_PTR_RST;
			port_r <= `PORT_RST;
		end else begin
			if (a_we) accum_r <= a_wd;
			if (flag_upd && alu_res.zero_we) begin
				zero_r <= alu_res.res == 8'h00;
			end
			if (flag_upd && alu_res.carry_we) carry_r <= alu_res.carry;
			if (m_we && is_tblp) tblp_r <= m_wd;
			if (m_we && is_port) port_r <= m_wd;
		end
	end

	// data memory, no reset
	always_ff @(posedge mclk_in) begin
		if (m_we && in_dm && !is_pcl && !is_tblp && !is_port) begin
			dm_r[m_addr[DM_AW-1:0]] <= m_wd;
		end
	end

	// return address stack
	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			sp_r <= '0;
		end else if (step && k == instr_pkg::K_CALL) begin
			sp_r <= sp_r + 1'b1;
		end else if (step && k_ret) begin
			sp_r <= sp_r - 1'b1;
		end
	end

	// stack storage
	always_ff @(posedge mclk_in) begin
		if (step && k == instr_pkg::K_CALL) stack_r[sp_r] <= pc_r;
	end

	// power-down and wake synchroniser
	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			wake_m_r <= 1'b0;
			wake_s_r <= 1'b0;
			pd_r <= 1'b0;
		end else begin
			wake_m_r <= wake_in;
			wake_s_r <= wake_m_r;
			if (step && k == instr_pkg::K_POWER_DOWN) begin
				pd_r <= 1'b1;
			end else if (wake_s_r) begin
				pd_r <= 1'b0;
			end
		end
	end

	assign prog_addr_out = prog_addr_r;
	assign accum_out = accum_r;
	assign zero_out = zero_r;
	assign carry_out = carry_r;
	assign port_out = port_r;
	assign power_down_out = pd_r;
	assign icycle_last_out = icyc_r;

	// checks
	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (!rst_n_in);

	phase_wrap_a: assert property (cyc_end |=> phase_r == 2'h0 ##3 cyc_end)
		else $error("instruction cycle is not four clocks");
	jump_two_a: assert property (step && k == instr_pkg::K_JUMP |=>
		flush_r [*4] ##1 !flush_r) else $error("jump not two cycles");
	pcl_write_a: assert property (pcl_wr |=> flush_r &&
		pc_r[7:0] == $past(m_wd)) else $error("pc low write not a jump");
	skip_taken_a: assert property (step && k_skip && skip_hit |=>
		flush_r && pc_r == $past(pc_r) + 1'b1) else $error("skip not taken");
	skip_none_a: assert property (step && k_skip && !skip_hit |=>
		!flush_r) else $error("untaken skip cost a cycle");
	add_carry_a: assert property (flag_upd && ir_r.fn == instr_pkg::FN_ADD
		|=> carry_r == (({1'b0, $past(accum_r)} + {1'b0, $past(b_op)})
		> 9'd255)) else $error("add carry wrong");
	inc_one_a: assert property (a_we && k_alu &&
		ir_r.fn == instr_pkg::FN_INC |=> accum_r == $past(b_op) + 8'h01)
		else $error("increment not by one");
	zero_flag_a: assert property (flag_upd && ir_r.fn == instr_pkg::FN_XOR
		|=> zero_r == ($past(accum_r) == $past(b_op)))
		else $error("zero flag wrong");
	rot_carry_a: assert property (a_we && k_alu &&
		ir_r.fn == instr_pkg::FN_ROT_RIGHT_CARRY |=> carry_r == $past(b_op[0])
		&& accum_r == {$past(carry_r), $past(b_op[7:1])})
		else $error("rotate through carry wrong");
	call_ret_a: assert property (step && k == instr_pkg::K_CALL |=>
		stack_top == $past(pc_r)) else $error("return address wrong");
	bit_only_a: assert property (m_we && k == instr_pkg::K_BIT_SET |->
		(m_wd ^ m_rd) == (bmask & ~m_rd)) else $error("bit set disturbs bits");
	table_a: assert property (step && k_tab |=>
		accum_r == $past(prog_data_in.operand[7:0]) && flush_r)
		else $error("table read wrong");
	halt_a: assert property (step && k == instr_pkg::K_POWER_DOWN |=> pd_r)
		else $error("power-down not entered");

	jump_c: cover property (step && k == instr_pkg::K_JUMP);
	skip_c: cover property (step && k_skip && skip_hit);
	table_c: cover property (step && k_tab);
	wake_c: cover property (pd_r ##1 !pd_r);
endmodule

// ===== tb/tb.sv
`timescale 1ns/10ps
`define CHK(got, exp) \
	begin \
		tests_run++; \
		if ((got) !== (exp)) begin \
			mismatches++; \
			$display("mismatch at %0t: got %h want %h", $time, got, exp); \
		end \
	end
module tb;
	logic mclk_in = 1'b0;
	logic rst_n_in = 1'b0;
	logic wake_in = 1'b0;
	instr_pkg::instr_t prog_data_in = '0;
	logic [10:0] prog_addr_out;
	logic [7:0] accum_out;
	logic [7:0] port_out;
	logic zero_out, carry_out, power_down_out, icycle_last_out;
	instr_pkg::instr_t rom [0:127];
	logic [7:0] e_acc [0:31];
	logic [7:0] e_port [0:31];
	logic [3:0] e_flg [0:31];
	int mismatches = 0;
	int tests_run = 0;
	int nrow = 0;
	int n;
	logic [10:0] fa;
	// fetch address and accumulator after each cycle of the branch section
	logic [18:0] trace [0:27] = '{
		19'h0_1780, 19'h0_3080, 19'h0_3180, 19'h0_4080, 19'h0_415a, 19'h0_315a,
		19'h0_325a, 19'h0_445a, 19'h0_455a, 19'h0_325a, 19'h0_335a, 19'h0_465a,
		19'h0_475a, 19'h0_335a, 19'h0_345a, 19'h0_355a, 19'h0_365a, 19'h0_3711,
		19'h0_3811, 19'h0_3922, 19'h0_3a22, 19'h0_3b22, 19'h0_00f0, 19'h0_3cf0,
		19'h0_3d50, 19'h0_3e50, 19'h0_5050, 19'h0_5150};

	always #2 mclk_in = ~mclk_in;

	instruction_cycle_timing #(.PC_W(11), .DM_DEPTH(64), .STACK_DEPTH(8)) u_dut (
		.mclk_in(mclk_in),
		.rst_n_in(rst_n_in),
		.prog_data_in(prog_data_in),
		.wake_in(wake_in),
		.prog_addr_out(prog_addr_out),
		.accum_out(accum_out),
		.zero_out(zero_out),
		.carry_out(carry_out),
		.port_out(port_out),
		.power_down_out(power_down_out),
		.icycle_last_out(icycle_last_out)
	);

	// program memory answers one clock after the address, well before phase 3
	always @(posedge mclk_in) begin
		prog_data_in <= rom[prog_addr_out[6:0]];
	end

	// one row: word, then accumulator, flags, port and flag-check enable
	task automatic r(input instr_pkg::kind_t k, input instr_pkg::alu_fn_t f,
		input logic tm, input logic [2:0] b, input logic [10:0] op,
		input logic [7:0] a, input logic z, input logic c,
		input logic [7:0] p, input logic cf);
		rom[nrow] = '{k, f, tm, b, op};
		e_acc[nrow] = a;
		e_port[nrow] = p;
		e_flg[nrow] = {cf, z, c, 1'b0};
		nrow++;
	endtask

	// control word, no alu function
	task automatic w(input logic [6:0] a, input instr_pkg::kind_t k,
		input logic [2:0] b, input logic [10:0] op);
		rom[a] = '{k, instr_pkg::FN_PASS, k != instr_pkg::K_ALU_IMM, b, op};
	endtask

	// run to the end of one instruction cycle, keep its fetch address
	task automatic icyc();
		n = 0;
		do begin
			@(posedge mclk_in);
			#1;
			n++;
		end while (icycle_last_out !== 1'b1 && n < 20);
		fa = prog_addr_out;
		@(posedge mclk_in);
		#1;
		n++;
	endtask

	task automatic tally_and_finish();
		$display("mismatches %0d tests_run %0d", mismatches, tests_run);
		if (mismatches == 0 && tests_run > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	// watchdog far beyond the few hundred clocks the run needs
	initial begin
		#20000;
		mismatches++;
		$display("mismatch at %0t: watchdog expired", $time);
		tally_and_finish();
	end

	// main sequence
	initial begin
		for (int i = 0; i < 128; i++) begin
			rom[i] = '0;
		end
		r(instr_pkg::K_ALU_IMM, instr_pkg::FN_PASS, 0, 3'h0, 11'h0f0,
			8'hf0, 0, 0, 8'h00, 0);
		r(instr_pkg::K_ALU_IMM, instr_pkg::FN_ADD, 0, 3'h0, 11'h020,
			8'h10, 0, 1, 8'h00, 1);
		r(instr_pkg::K_ALU_IMM, instr_pkg::FN_SUB, 0, 3'h0, 11'h011,
			8'hff, 0, 0, 8'h00, 1);
		r(instr_pkg::K_ALU_IMM, instr_pkg::FN_SUB, 0, 3'h0, 11'h00f,
			8'hf0, 0, 1, 8'h00, 1);
		r(instr_pkg::K_ALU_IMM, instr_pkg::FN_AND, 0, 3'h0, 11'h00f,
			8'h00, 1, 1, 8'h00, 1);
		r(instr_pkg::K_ALU_IMM, instr_pkg::FN_OR, 0, 3'h0, 11'h081,
			8'h81, 0, 1, 8'h00, 1);
		r(instr_pkg::K_ALU_IMM, instr_pkg::FN_XOR, 0, 3'h0, 11'h081,
			8'h00, 1, 1, 8'h00, 1);
		r(instr_pkg::K_MOVE_TO_MEM, instr_pkg::FN_PASS, 1, 3'h0, 11'h010,
			8'h00, 1, 1, 8'h00, 1);
		r(instr_pkg::K_ALU_MEM, instr_pkg::FN_DEC, 0, 3'h0, 11'h010,
			8'hff, 0, 1, 8'h00, 1);
		r(instr_pkg::K_ALU_MEM, instr_pkg::FN_INC, 1, 3'h0, 11'h010,
			8'hff, 0, 1, 8'h00, 1);
		r(instr_pkg::K_ALU_MEM, instr_pkg::FN_PASS, 0, 3'h0, 11'h010,
			8'h01, 0, 1, 8'h00, 0);
		r(instr_pkg::K_ALU_IMM, instr_pkg::FN_ADD, 0, 3'h0, 11'h0ff,
			8'h00, 1, 1, 8'h00, 1);
		r(instr_pkg::K_ALU_MEM, instr_pkg::FN_ROT_RIGHT_CARRY, 0, 3'h0, 11'h010,
			8'h80, 1, 1, 8'h00, 1);
		r(instr_pkg::K_ALU_MEM, instr_pkg::FN_ROT_LEFT_CARRY, 1, 3'h0, 11'h010,
			8'h80, 1, 0, 8'h00, 1);
		r(instr_pkg::K_ALU_MEM, instr_pkg::FN_ROT_RIGHT, 1, 3'h0, 11'h010,
			8'h80, 1, 0, 8'h00, 1);
		r(instr_pkg::K_ALU_MEM, instr_pkg::FN_ROT_LEFT, 0, 3'h0, 11'h010,
			8'h03, 1, 0, 8'h00, 1);
		r(instr_pkg::K_MOVE_TO_MEM, instr_pkg::FN_PASS, 1, 3'h0, 11'h008,
			8'h03, 1, 0, 8'h03, 1);
		r(instr_pkg::K_BIT_SET, instr_pkg::FN_PASS, 1, 3'h7, 11'h008,
			8'h03, 1, 0, 8'h83, 1);
		r(instr_pkg::K_BIT_CLEAR, instr_pkg::FN_PASS, 1, 3'h1, 11'h008,
			8'h03, 1, 0, 8'h81, 1);
		r(instr_pkg::K_ALU_MEM, instr_pkg::FN_COMPLEMENT, 0, 3'h0, 11'h010,
			8'h7e, 0, 0, 8'h81, 1);
		r(instr_pkg::K_ALU_IMM, instr_pkg::FN_ADD_CARRY, 0, 3'h0, 11'h002,
			8'h80, 0, 0, 8'h81, 1);
		r(instr_pkg::K_ALU_IMM, instr_pkg::FN_SUB_CARRY, 0, 3'h0, 11'h0ff,
			8'h80, 0, 0, 8'h81, 1);
		// branch, skip, table and power-down section
		w(7'h16, instr_pkg::K_JUMP, 3'h0, 11'h030);
		w(7'h30, instr_pkg::K_CALL, 3'h0, 11'h040);
		w(7'h40, instr_pkg::K_RETURN_IMM, 3'h0, 11'h05a);
		w(7'h31, instr_pkg::K_CALL, 3'h0, 11'h044);
		w(7'h44, instr_pkg::K_INT_RETURN, 3'h0, 11'h000);
		w(7'h32, instr_pkg::K_CALL, 3'h0, 11'h046);
		w(7'h46, instr_pkg::K_RETURN, 3'h0, 11'h000);
		w(7'h33, instr_pkg::K_SKIP_ZERO, 3'h0, 11'h010);
		w(7'h34, instr_pkg::K_SKIP_BIT_SET, 3'h0, 11'h010);
		w(7'h35, instr_pkg::K_ALU_IMM, 3'h0, 11'h077);
		w(7'h36, instr_pkg::K_ALU_IMM, 3'h0, 11'h011);
		w(7'h37, instr_pkg::K_SKIP_BIT_ZERO, 3'h0, 11'h010);
		w(7'h38, instr_pkg::K_ALU_IMM, 3'h0, 11'h022);
		w(7'h39, instr_pkg::K_SKIP_ZERO, 3'h0, 11'h050);
		w(7'h3a, instr_pkg::K_ALU_IMM, 3'h0, 11'h033);
		w(7'h3b, instr_pkg::K_TABLE_READ, 3'h0, 11'h000);
		w(7'h3c, instr_pkg::K_ALU_IMM, 3'h0, 11'h050);
		w(7'h3d, instr_pkg::K_MOVE_TO_MEM, 3'h0, 11'h006);
		w(7'h50, instr_pkg::K_POWER_DOWN, 3'h0, 11'h000);
		w(7'h51, instr_pkg::K_ALU_IMM, 3'h0, 11'h066);
		repeat (4) @(posedge mclk_in);
		rst_n_in <= 1'b1;
		icyc();
		// row k lands in the cycle that fetches address k + 1
		for (int k = 0; k < nrow; k++) begin
			icyc();
			`CHK(n, 4)
			`CHK(fa, 11'(k + 1))
			`CHK(accum_out, e_acc[k])
			`CHK(port_out, e_port[k])
			if (e_flg[k][3]) begin
				`CHK(zero_out, e_flg[k][2])
				`CHK(carry_out, e_flg[k][1])
			end
		end
		for (int k = 0; k < 28; k++) begin
			icyc();
			`CHK(fa, trace[k][18:8])
			`CHK(accum_out, trace[k][7:0])
		end
		`CHK(power_down_out, 1'b1)
		repeat (3) icyc();
		`CHK(accum_out, 8'h50)
		@(posedge mclk_in);
		wake_in <= 1'b1;
		repeat (6) @(posedge mclk_in);
		wake_in <= 1'b0;
		n = 0;
		while (power_down_out !== 1'b0 && n < 40) begin
			@(posedge mclk_in);
			#1;
			n++;
		end
		`CHK(power_down_out, 1'b0)
		for (int m = 0; m < 4 && accum_out !== 8'h66; m++) begin
			icyc();
		end
		`CHK(accum_out, 8'h66)
		// second reset in mid-run clears every output
		@(posedge mclk_in);
		rst_n_in <= 1'b0;
		@(posedge mclk_in);
		#1;
		`CHK({prog_addr_out, accum_out, port_out}, 27'h000_0000)
		`CHK({zero_out, carry_out, power_down_out, icycle_last_out}, 4'h0)
		// release again: first cycle is four clocks and fetches address 0
		@(posedge mclk_in);
		rst_n_in <= 1'b1;
		icyc();
		`CHK(n, 4)
		`CHK(fa, 11'h000)
		tally_and_finish();
	end
endmodule
